// File: core/erp_port_ctrl.sv
// port-side control of an embedded ram/rom: clock modes, stall, byte enables, clear
//
// Summary of operation
// - single clock mode: one clock tick and one enable drive every register
// - read/write mode: read tick drives read side, write tick drives write side
// - input/output mode: input tick drives all inputs, output tick only outputs
// - independent mode: port A registers on tick A, port B on tick B
// - optional separate clock enables for input and output registers per port
// - read/write only for simple dual-port; independent only true dual or dual rom
// - address stall high keeps the port address register unchanged
// - each port has its own stall acting only on its own address
// - stall inactive by default so addresses load normally
// - write stores only enabled lanes; masked lanes keep old contents
// - byte enable bit 0 governs the lowest lane, upward from there
// - lane size 5, 8, 9 or 10; 5 and 10 only on distributed memory
// - byte enables allowed only for port width ratio 1 or 2
// - byte enables need data width a multiple of lane; width is the quotient
// - new-data rdw: masked lane reads undefined fill or current contents
// - clear zeroes output registers and latches; not on distributed memory
// - cleared outputs stay zero until next output tick, or next read if newer
// - clear touches only register stages, never the array
// - single-port ram keeps inputs; dual-port ram may clear only read address
// - single-port rom may clear address; dual-port rom keeps all inputs
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`include "erp_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module erp_port_ctrl #(
	parameter int ADDR_W      = 4,
	parameter int DATA_W      = 18,
	parameter int LANE_W      = 9,
	parameter int WIDTH_RATIO = 1,
	parameter bit DISTRIBUTED = 1'b0,
	parameter bit OUT_REG     = 1'b1
) (
	// clock and reset
	input  wire logic                         clock_in,
	input  wire logic                         rst_n_in,
	// avalon-mm register slave
	input  wire logic [3:0]                   avs_address_in,
	input  wire logic                         avs_read_in,
	input  wire logic                         avs_write_in,
	input  wire logic [31:0]                  avs_writedata_in,
	output logic      [31:0]                  avs_readdata_out,
	output logic                              avs_waitrequest_out,
	// port clock ticks and clock enables, index 0 = port a, 1 = port b
	input  wire logic [1:0]                   tick_in,
	input  wire logic [1:0]                   ce_in_in,
	input  wire logic [1:0]                   ce_out_in,
	// port requests
	input  wire logic [1:0][ADDR_W-1:0]       addr_in,
	input  wire logic [1:0][DATA_W-1:0]       data_in,
	input  wire logic [1:0]                   wren_in,
	input  wire logic [1:0][DATA_W/LANE_W-1:0] byteen_in,
	input  wire logic [1:0]                   addr_stall_in,
	input  wire logic [1:0]                   clear_in,
	// port read data
	output logic      [1:0][DATA_W-1:0]       q_out
);

	// ======================================================================
	// derived sizes and byte enable legality
	localparam int DEPTH = 2 ** ADDR_W;
	localparam int BE_W  = DATA_W / LANE_W;
	localparam bit LANE_LEGAL = (LANE_W == 8) || (LANE_W == 9) ||
		(DISTRIBUTED && ((LANE_W == 5) || (LANE_W == 10)));
	localparam bit BE_OK = LANE_LEGAL && (DATA_W % LANE_W == 0) &&
		((WIDTH_RATIO == 1) || (WIDTH_RATIO == 2));

	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0]  mem;
		logic [1:0][ADDR_W-1:0]        addr;
		logic [1:0][DATA_W-1:0]        din;
		logic [1:0]                    we;
		logic [1:0][BE_W-1:0]          be;
		logic [1:0]                    fresh;
		logic [1:0][DATA_W-1:0]        latch;
		logic [1:0][DATA_W-1:0]        oreg;
		logic [1:0]                    hold;
		logic [`ERP_CTRL_W-1:0]        ctrl;
		logic [`ERP_WCOUNT_W-1:0]      wcnt;
		logic                          wait_r;
		logic [31:0]                   rdata;
	} erp_state_t;

	erp_state_t s_q;
	erp_state_t s_d;

	// ======================================================================
	// decoded configuration
	erp_pkg::erp_mem_mode_t mem_mode;
	erp_pkg::erp_clk_mode_t clk_req;
	erp_pkg::erp_clk_mode_t clk_eff;
	logic                   illegal;
	logic [1:0]             itk;
	logic [1:0]             otk;
	logic [1:0]             ce_i;
	logic [1:0]             ce_o;
	logic [1:0]             in_ev;
	logic [1:0]             out_ev;
	logic [1:0]             used;
	logic [1:0]             can_wr;
	logic [1:0]             stall_en;

	// mode legality; an unsupported combination falls back to single clock
	always_comb begin
		mem_mode = erp_pkg::erp_mem_mode_t'(s_q.ctrl[`ERP_CTRL_MEM_HI:`ERP_CTRL_MEM_LO]);
		clk_req  = erp_pkg::erp_clk_mode_t'(s_q.ctrl[`ERP_CTRL_CLK_HI:`ERP_CTRL_CLK_LO]);
		stall_en = s_q.ctrl[`ERP_CTRL_STALL_HI:`ERP_CTRL_STALL_LO];
		used     = 2'b01;
		can_wr   = 2'b00;
		illegal  = 1'b0;
		case (mem_mode)
			erp_pkg::ERP_SP_RAM: begin
				can_wr = 2'b01;
			end
			erp_pkg::ERP_SDP_RAM: begin
				used   = 2'b11;
				can_wr = 2'b01;
			end
			erp_pkg::ERP_TDP_RAM: begin
				used   = 2'b11;
				can_wr = 2'b11;
			end
			erp_pkg::ERP_SP_ROM: begin
				used = 2'b01;
			end
			erp_pkg::ERP_DP_ROM: begin
				used = 2'b11;
			end
			default: begin
				illegal = 1'b1;
			end
		endcase
		if (clk_req == erp_pkg::ERP_CLK_RW && mem_mode != erp_pkg::ERP_SDP_RAM) begin
			illegal = 1'b1;
		end
		if (clk_req == erp_pkg::ERP_CLK_INDEP && mem_mode != erp_pkg::ERP_TDP_RAM &&
			mem_mode != erp_pkg::ERP_DP_ROM) begin
			illegal = 1'b1;
		end
		clk_eff = illegal ? erp_pkg::ERP_CLK_SINGLE : clk_req;
	end

	// route port ticks to register groups per clocking mode
	always_comb begin
		case (clk_eff)
			erp_pkg::ERP_CLK_SINGLE: begin
				itk = {tick_in[0], tick_in[0]};
				otk = {tick_in[0], tick_in[0]};
			end
			erp_pkg::ERP_CLK_RW: begin
				itk = {tick_in[1], tick_in[0]};
				otk = {tick_in[1], tick_in[1]};
			end
			erp_pkg::ERP_CLK_IO: begin
				itk = {tick_in[0], tick_in[0]};
				otk = {tick_in[1], tick_in[1]};
			end
			erp_pkg::ERP_CLK_INDEP: begin
				itk = tick_in;
				otk = tick_in;
			end
			default: begin
				itk = {tick_in[0], tick_in[0]};
				otk = {tick_in[0], tick_in[0]};
			end
		endcase
		// single mode, or shared enables, use the port a input enable everywhere
		if (s_q.ctrl[`ERP_CTRL_INDEP_CE] && clk_eff != erp_pkg::ERP_CLK_SINGLE) begin
			ce_i = ce_in_in;
			ce_o = ce_out_in;
		end else begin
			ce_i = {ce_in_in[0], ce_in_in[0]};
			ce_o = {ce_in_in[0], ce_in_in[0]};
		end
		in_ev  = itk & ce_i & used;
		out_ev = otk & ce_o & used;
	end

	// ======================================================================
	// next state
	always_comb begin
		logic [BE_W-1:0]   be_eff;
		logic [DATA_W-1:0] old_w;
		logic [DATA_W-1:0] rd_w;
		logic              release_h;
		logic              clr_ok;
		logic [1:0]        wrote;
		be_eff    = '0;
		old_w     = '0;
		rd_w      = '0;
		release_h = 1'b0;
		clr_ok    = 1'b0;
		wrote     = 2'b00;
		s_d       = s_q;

		// input capture; held registers clear the fresh flag
		for (int p = 0; p < 2; p++) begin
			s_d.fresh[p] = in_ev[p];
			if (in_ev[p]) begin
				if (!(stall_en[p] && addr_stall_in[p])) begin
					s_d.addr[p] = addr_in[p];
				end
				s_d.din[p] = data_in[p];
				s_d.we[p]  = wren_in[p] & can_wr[p];
				s_d.be[p]  = byteen_in[p];
			end
		end

		// commit writes only from freshly captured registers
		for (int p = 0; p < 2; p++) begin
			be_eff = BE_OK ? s_q.be[p] : '1;
			if (s_q.fresh[p] && s_q.we[p]) begin
				wrote[p] = 1'b1;
				for (int i = 0; i < DATA_W; i++) begin
					if (be_eff[i / LANE_W]) begin
						s_d.mem[s_q.addr[p]][i] = s_q.din[p][i];
					end
				end
			end
		end
		if (wrote != 2'b00) begin
			s_d.wcnt = s_q.wcnt + `ERP_WCOUNT_W'(wrote[0]) + `ERP_WCOUNT_W'(wrote[1]);
		end

		// read into the output latch, then the output register
		for (int p = 0; p < 2; p++) begin
			be_eff = BE_OK ? s_q.be[p] : '1;
			old_w  = s_q.mem[s_q.addr[p]];
			rd_w   = old_w;
			if (wrote[p] && s_q.ctrl[`ERP_CTRL_RDW_NEW]) begin
				for (int i = 0; i < DATA_W; i++) begin
					// masked lane shows contents or an all-ones fill
					rd_w[i] = be_eff[i / LANE_W] ? s_q.din[p][i] :
						(s_q.ctrl[`ERP_CTRL_MASK_OLD] ? old_w[i] : 1'b1);
				end
			end
			release_h = s_q.ctrl[`ERP_CTRL_NEWER_CLR] ? s_q.fresh[p] : out_ev[p];
			if (s_q.hold[p] && release_h) begin
				s_d.hold[p] = 1'b0;
			end
			if (s_q.fresh[p] && (!s_q.hold[p] || release_h)) begin
				s_d.latch[p] = rd_w;
			end
			if (out_ev[p]) begin
				s_d.oreg[p] = s_q.latch[p];
			end

			// clear wins over loads; distributed memory has no clear
			if (clear_in[p] && !DISTRIBUTED) begin
				s_d.latch[p] = '0;
				s_d.oreg[p]  = '0;
				s_d.hold[p]  = 1'b1;
				clr_ok = 1'b0;
				case (mem_mode)
					erp_pkg::ERP_SDP_RAM: clr_ok = (p == 1);
					erp_pkg::ERP_TDP_RAM: clr_ok = !s_q.we[p];
					erp_pkg::ERP_SP_ROM:  clr_ok = (p == 0);
					default:              clr_ok = 1'b0;
				endcase
				// of the input registers only the address may clear; the array never does
				if (clr_ok && s_q.ctrl[`ERP_CTRL_CLR_ADDR]) begin
					s_d.addr[p] = '0;
				end
			end
		end

		// avalon slave: one wait cycle, then answer
		s_d.wait_r = !((avs_read_in || avs_write_in) && s_q.wait_r);
		if (avs_read_in && s_q.wait_r) begin
			case (avs_address_in)
				`ERP_REG_CTRL: begin
					s_d.rdata = 32'(s_q.ctrl);
				end
				`ERP_REG_STATUS: begin
					s_d.rdata = '0;
					s_d.rdata[`ERP_STAT_ILLEGAL]    = illegal;
					s_d.rdata[`ERP_STAT_BE_OK]      = BE_OK;
					s_d.rdata[`ERP_STAT_HOLD_LO+:2] = s_q.hold;
					s_d.rdata[`ERP_STAT_FRESH_LO+:2] = s_q.fresh;
					s_d.rdata[`ERP_STAT_CLK_LO+:2]  = clk_eff;
				end
				`ERP_REG_WCOUNT: begin
					s_d.rdata = 32'(s_q.wcnt);
				end
				default: begin
					s_d.rdata = `ERP_RDATA_RESET;
				end
			endcase
		end
		// a write takes effect at the edge where waitrequest is seen low
		if (avs_write_in && !s_q.wait_r && avs_address_in == `ERP_REG_CTRL) begin
			s_d.ctrl = avs_writedata_in[`ERP_CTRL_W-1:0];
		end
	end

	// ======================================================================
	// state register
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q        <= '0;
			s_q.ctrl   <= `ERP_CTRL_RESET;
			s_q.wait_r <= 1'b1;
			s_q.rdata  <= `ERP_RDATA_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// ======================================================================
	// outputs straight from state flops
	assign avs_readdata_out    = s_q.rdata;
	assign avs_waitrequest_out = s_q.wait_r;
	assign q_out               = OUT_REG ? s_q.oreg : s_q.latch;

endmodule

`default_nettype wire

// File: core/erp_port_cfg.svh
// constants for the embedded ram port control block: offsets, fields, resets, sizes
`ifndef ERP_PORT_CFG_SVH
`define ERP_PORT_CFG_SVH

// ==========================================================================
// register byte offsets on the avalon slave
`define ERP_REG_CTRL        4'h0
`define ERP_REG_STATUS      4'h4
`define ERP_REG_WCOUNT      4'h8

// ==========================================================================
// control register fields
`define ERP_CTRL_W          12
`define ERP_CTRL_MEM_LO     0
`define ERP_CTRL_MEM_HI     2
`define ERP_CTRL_CLK_LO     3
`define ERP_CTRL_CLK_HI     4
`define ERP_CTRL_INDEP_CE   5
`define ERP_CTRL_NEWER_CLR  6
`define ERP_CTRL_CLR_ADDR   7
`define ERP_CTRL_RDW_NEW    8
`define ERP_CTRL_MASK_OLD   9
`define ERP_CTRL_STALL_LO   10
`define ERP_CTRL_STALL_HI   11
`define ERP_CTRL_RESET      12'h000

// ==========================================================================
// status register fields
`define ERP_STAT_ILLEGAL    0
`define ERP_STAT_BE_OK      1
`define ERP_STAT_HOLD_LO    2
`define ERP_STAT_FRESH_LO   4
`define ERP_STAT_CLK_LO     6

// ==========================================================================
// misc reset values and sizes
`define ERP_WCOUNT_W        16
`define ERP_RDATA_RESET     32'h0000_0000

`endif

// File: core/erp_pkg.sv
// types shared by the embedded ram port control block
package erp_pkg;

	// ======================================================================
	// memory mode as held in the control register
	typedef enum logic [2:0] {
		ERP_SP_RAM,
		ERP_SDP_RAM,
		ERP_TDP_RAM,
		ERP_SP_ROM,
		ERP_DP_ROM
	} erp_mem_mode_t;

	// ======================================================================
	// clocking mode as held in the control register
	typedef enum logic [1:0] {
		ERP_CLK_SINGLE,
		ERP_CLK_RW,
		ERP_CLK_IO,
		ERP_CLK_INDEP
	} erp_clk_mode_t;

endpackage

// File: testbench/erp_port_ctrl_monitor.sv
// concurrent checks on the embedded ram port control ports
`timescale 1ns/1ps
`default_nettype none

module erp_port_ctrl_monitor #(
	parameter int DATA_W = 18
) (
	// clock and reset
	input wire logic                   clock_in,
	input wire logic                   rst_n_in,
	// avalon slave side
	input wire logic                   avs_read_in,
	input wire logic                   avs_write_in,
	input wire logic [31:0]            avs_readdata_out,
	input wire logic                   avs_waitrequest_out,
	// memory ports
	input wire logic [1:0]             tick_in,
	input wire logic [1:0]             clear_in,
	input wire logic [1:0][DATA_W-1:0] q_out
);
	// ==========
	// one domain, so clock and disable are shared
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	wire logic req = avs_read_in | avs_write_in;

	// bus handshake: exactly one wait state, low for one cycle
	property p_wait_one;
		req && avs_waitrequest_out |=> !avs_waitrequest_out;
	endproperty
	property p_wait_pulse;
		!avs_waitrequest_out |=> avs_waitrequest_out;
	endproperty
	property p_wait_idle;
		!req |=> avs_waitrequest_out;
	endproperty
	property p_wait_bound;
		req |-> ##[0:1] !avs_waitrequest_out;
	endproperty
	// read data only moves in answer to a read
	property p_rd_hold;
		!avs_read_in |=> $stable(avs_readdata_out);
	endproperty
	// clear zeroes the outputs of its own port
	property p_clr_a;
		clear_in[0] |=> q_out[0] == '0;
	endproperty
	property p_clr_b;
		clear_in[1] |=> q_out[1] == '0;
	endproperty
	// without any tick the output registers do not load; this also keeps a cleared zero
	property p_q_hold;
		!(|tick_in) && !(|clear_in) |=> $stable(q_out);
	endproperty

	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest did not drop after one wait state");
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("waitrequest low longer than one cycle");
	a_wait_idle: assert property (p_wait_idle)
		else $error("waitrequest low without a request");
	a_wait_bound: assert property (p_wait_bound)
		else $error("request not answered in time");
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without a read");
	a_clr_a: assert property (p_clr_a)
		else $error("port a output not cleared");
	a_clr_b: assert property (p_clr_b)
		else $error("port b output not cleared");
	a_q_hold: assert property (p_q_hold)
		else $error("output changed without a tick");

	// main scenarios reached
	c_write: cover property (avs_write_in && !avs_waitrequest_out);
	c_clear: cover property (clear_in == 2'h3);
	c_burst: cover property (tick_in[0] ##1 tick_in[0] ##1 tick_in[0]);
endmodule

bind erp_port_ctrl erp_port_ctrl_monitor #(.DATA_W(DATA_W)) mon_u (
	.clock_in, .rst_n_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
	.avs_waitrequest_out, .tick_in, .clear_in, .q_out
);

`default_nettype wire

// File: testbench/erp_user_model.sv
// fabric user logic model driving the memory ports
`timescale 1ns/1ps
`default_nettype none

module erp_user_model (
	// clock
	input  wire logic             clock_in,
	// port requests, index 0 = port a
	output logic [1:0]            tick_out,
	output logic [1:0]            ce_in_out,
	output logic [1:0]            ce_out_out,
	output logic [1:0][3:0]       addr_out,
	output logic [1:0][17:0]      data_out,
	output logic [1:0]            wren_out,
	output logic [1:0][1:0]       byteen_out,
	output logic [1:0]            stall_out,
	output logic [1:0]            clear_out
);
	// ==========
	// quiet start: no tick, enables on
	initial begin
		tick_out = 2'h0;
		ce_in_out = 2'h3;
		ce_out_out = 2'h3;
		addr_out = '0;
		data_out = '0;
		wren_out = 2'h0;
		byteen_out = '0;
		stall_out = 2'h0;
		clear_out = 2'h0;
	end

	// one cycle of requests; idle address, data and port b byte-enable lines toggle so stale values never look valid
	task automatic put(input logic [1:0] t, input logic [1:0] ce, input logic [3:0] a,
			input logic [17:0] d, input logic w, input logic [1:0] be,
			input logic [1:0] st, input logic [1:0] cl);
		tick_out <= t & ~cl;
		ce_in_out <= ce;
		ce_out_out <= ce;
		addr_out[0] <= t[0] ? a : ~addr_out[0];
		addr_out[1] <= t[1] ? a : ~addr_out[1];
		data_out[0] <= t[0] ? d : ~data_out[0];
		data_out[1] <= t[1] ? d : ~data_out[1];
		wren_out <= {w & t[1], w & t[0]};
		byteen_out <= {t[1] ? be : ~byteen_out[1], be};
		stall_out <= st;
		clear_out <= cl;
		@(posedge clock_in);
	endtask
endmodule

`default_nettype wire

// File: testbench/tb_erp_port_ctrl.sv
// self-checking testbench for the embedded ram port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_erp_port_ctrl;
	logic                clock_in;
	logic                rst_n_in;
	logic [3:0]          avs_addr;
	logic                avs_read;
	logic                avs_write;
	logic [31:0]         avs_wdata;
	logic [31:0]         avs_rdata;
	logic                avs_wait;
	logic [1:0]          tick;
	logic [1:0]          ce_i;
	logic [1:0]          ce_o;
	logic [1:0][3:0]     addr;
	logic [1:0][17:0]    data;
	logic [1:0]          wren;
	logic [1:0][1:0]     byteen;
	logic [1:0]          stall;
	logic [1:0]          clear;
	logic [1:0][17:0]    q_out;
	int                  miscompares = 0;
	int                  cmp_count = 0;

	erp_port_ctrl dut_u (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .avs_address_in(avs_addr),
		.avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
		.avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait), .tick_in(tick),
		.ce_in_in(ce_i), .ce_out_in(ce_o), .addr_in(addr), .data_in(data),
		.wren_in(wren), .byteen_in(byteen), .addr_stall_in(stall), .clear_in(clear),
		.q_out(q_out)
	);
	erp_user_model p_u (
		.clock_in(clock_in), .tick_out(tick), .ce_in_out(ce_i), .ce_out_out(ce_o),
		.addr_out(addr), .data_out(data), .wren_out(wren), .byteen_out(byteen),
		.stall_out(stall), .clear_out(clear)
	);

	// ==========
	// 25 mhz clock
	initial begin
		clock_in = 1'h0;
		forever #20 clock_in = ~clock_in;
	end

	// verdict and end of run
	task automatic stop_test();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
			output logic [31:0] rd);
		avs_write <= w;
		avs_read <= ~w;
		avs_addr <= a;
		avs_wdata <= wd;
		do @(posedge clock_in); while (avs_wait !== 1'h0);
		rd = avs_rdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		@(posedge clock_in);
	endtask

	// port a write, then one idle cycle
	task automatic wr(input logic [3:0] a, input logic [17:0] d, input logic [1:0] be);
		p_u.put(2'h1, 2'h3, a, d, 1'h1, be, 2'h0, 2'h0);
		p_u.put(2'h0, 2'h3, a, d, 1'h0, be, 2'h0, 2'h0);
	endtask

	// port a read: capture, latch, output tick, then settle
	task automatic rdq(input logic [3:0] a, input logic [1:0] st);
		repeat (3) p_u.put(2'h1, 2'h3, a, 18'h0_0000, 1'h0, 2'h0, st, 2'h0);
		p_u.put(2'h0, 2'h3, a, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
	endtask

	// port a write, one output tick, then idle: q shows what the latch took at commit
	task automatic wq(input logic [3:0] a, input logic [17:0] d, input logic [1:0] be);
		wr(a, d, be);
		p_u.put(2'h1, 2'h3, a, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		p_u.put(2'h0, 2'h3, a, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
	endtask

	// watchdog, far beyond the hundred or so cycles the tests need
	initial begin
		repeat (5000) @(posedge clock_in);
		miscompares++;
		stop_test();
	end

	// ==========
	// main sequence
	initial begin
		logic [31:0] rd;
		logic [17:0] m;
		logic [17:0] nv;
		logic [17:0] msk;
		rst_n_in = 1'h0;
		avs_addr = 4'h0;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_wdata = 32'h0000_0000;
		repeat (3) @(posedge clock_in);
		rst_n_in <= 1'h1;
		@(posedge clock_in);
		bus(1'h0, 4'h0, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
		`CHK(q_out, '0)
		m = 18'h2_AAAA;
		wr(4'h1, m, 2'h3);
		rdq(4'h1, 2'h0);
		`CHK(q_out[0], m)
		// every byte-enable pattern over an inverted word
		for (int b = 0; b < 4; b++) begin
			nv = ~m;
			msk = {{9{b[1]}}, {9{b[0]}}};
			wr(4'h1, nv, b[1:0]);
			m = (nv & msk) | (m & ~msk);
			rdq(4'h1, 2'h0);
			`CHK(q_out[0], m)
		end
		// tick with the clock enable low must not write
		p_u.put(2'h1, 2'h0, 4'h1, ~m, 1'h1, 2'h3, 2'h0, 2'h0);
		rdq(4'h1, 2'h0);
		`CHK(q_out[0], m)
		// enable stall on port a, then stall while presenting another address
		bus(1'h1, 4'h0, 32'h0000_0400, rd);
		bus(1'h0, 4'h0, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0400)
		wr(4'h2, 18'h0_1234, 2'h3);
		p_u.put(2'h1, 2'h3, 4'h1, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		rdq(4'h2, 2'h3);
		`CHK(q_out[0], m)
		// clear both ports, zero held until the next read
		p_u.put(2'h0, 2'h3, 4'h1, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h3);
		repeat (2) p_u.put(2'h0, 2'h3, 4'h1, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		`CHK(q_out, '0)
		rdq(4'h1, 2'h0);
		`CHK(q_out[0], m)
		bus(1'h0, 4'hC, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
		// six writes committed so far, none from held registers
		bus(1'h0, 4'h8, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0006)
		// new-data rdw: masked lane reads all ones, then the old contents
		bus(1'h1, 4'h0, 32'h0000_0100, rd);
		wq(4'h5, 18'h1_2345, 2'h1);
		`CHK(q_out[0], 18'h3_FF45)
		bus(1'h1, 4'h0, 32'h0000_0300, rd);
		wq(4'h5, 18'h2_AA00, 2'h2);
		`CHK(q_out[0], 18'h2_AB45)
		// simple dual-port on read/write clocks: a writes on tick a, b reads on tick b
		bus(1'h1, 4'h0, 32'h0000_0009, rd);
		wr(4'h3, 18'h3_0F0F, 2'h3);
		repeat (3) p_u.put(2'h2, 2'h3, 4'h3, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		p_u.put(2'h0, 2'h3, 4'h3, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		`CHK(q_out[1], 18'h3_0F0F)
		// read/write clocks on single-port ram: flagged illegal, single clock used
		bus(1'h1, 4'h0, 32'h0000_0008, rd);
		bus(1'h0, 4'h4, 32'h0000_0000, rd);
		`CHK(rd & 32'h0000_00C3, 32'h0000_0003)
		// input/output clocks, newer release: a read frees the latch, only tick b shows it
		bus(1'h1, 4'h0, 32'h0000_0050, rd);
		p_u.put(2'h0, 2'h3, 4'h1, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h1);
		rdq(4'h1, 2'h0);
		`CHK(q_out[0], 18'h0_0000)
		p_u.put(2'h2, 2'h3, 4'h1, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		p_u.put(2'h0, 2'h3, 4'h1, 18'h0_0000, 1'h0, 2'h0, 2'h0, 2'h0);
		`CHK(q_out[0], m)
		stop_test();
	end
endmodule

`default_nettype wire
